// ==== rst_source_tracker_regs.vh ====
// Purpose: constants of the reset source tracker
// Assumes: included by bare name, once per file
// Notes: byte addresses on the register bus
`ifndef RST_SOURCE_TRACKER_REGS_VH
`define RST_SOURCE_TRACKER_REGS_VH
// ==========================================
// Register map
`define RST_ADDR_W 4
`define RST_ADDR_STATUS 4'h0
// ==========================================
// Field positions of reset_cause_status
`define RST_BIT_IRQ_PRIORITY_LEVELS_ON 7
`define RST_BIT_UNUSED 6
`define RST_BIT_CM 5
`define RST_BIT_RI 4
`define RST_BIT_TO 3
`define RST_BIT_PD 2
`define RST_BIT_POR 1
`define RST_BIT_BOR 0
`define RST_STATUS_RESET 8'h3c
`define RST_STATUS_WMASK 8'hb3
// ==========================================
// Timing
`define RST_CLK_PERIOD_NS 4
`define RST_FILTER_NS 20
`define RST_FILTER_CYC \
	((`RST_FILTER_NS + `RST_CLK_PERIOD_NS - 1) / `RST_CLK_PERIOD_NS)
`define RST_POWERUP_TIMER_BITS 11
`define RST_POWERUP_TIMER_COUNT 2048
`define RST_HOLD_CYC 8
`endif

// ==== rst_source_tracker.v ====
// Purpose: reset cause tracking and core reset sequencing
// Assumes: one clock clk_i at 250 MHz, classic Wishbone slave
// Notes: pin, supply and RC clock inputs pass a 3-flop chain
//        hardware events win over a same-cycle software write
//        timer length counts RC edges; sim may shorten POWERUP_TIMER_COUNT
`include "rst_source_tracker_regs.vh"
`default_nettype none

module rst_source_tracker #(
	parameter CFG_W = 16,
	parameter FILTER_CYC = `RST_FILTER_CYC,
	parameter POWERUP_TIMER_BITS = `RST_POWERUP_TIMER_BITS,
	parameter POWERUP_TIMER_COUNT = `RST_POWERUP_TIMER_COUNT,
	parameter HOLD_CYC = `RST_HOLD_CYC
) (
	input wire clk_i,
	input wire rst_i,
	input wire [`RST_ADDR_W-1:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg wb_ack_o,
	input wire external_reset_pin_n_i,
	output reg external_reset_pin_o,
	output reg external_reset_pin_oe_o,
	input wire power_on_i,
	input wire brownout_i,
	input wire regulator_enable_pin_i,
	input wire internal_rc_clock_i,
	input wire [CFG_W-1:0] cfg_word_i,
	input wire [CFG_W-1:0] cfg_shadow_i,
	input wire reset_instr_i,
	input wire watchdog_clear_instr_i,
	input wire sleep_instr_i,
	input wire watchdog_timeout_i,
	output reg core_reset_o,
	output reg cfg_reload_o,
	output reg irq_priority_levels_on_o
);

	// ==========================================
	// Terminal counts
	// Worked out at full width, then cut to the counter widths;
	// a POWERUP_TIMER_COUNT above 2**POWERUP_TIMER_BITS would wrap, so keep them paired
	localparam [31:0] POWERUP_TIMER_LAST_W = POWERUP_TIMER_COUNT - 1;
	localparam [31:0] FILT_LAST_W = FILTER_CYC - 1;
	localparam [31:0] HOLD_LOAD_W = HOLD_CYC;
	localparam [POWERUP_TIMER_BITS-1:0] POWERUP_TIMER_LAST = POWERUP_TIMER_LAST_W[POWERUP_TIMER_BITS-1:0];
	localparam [7:0] FILT_LAST = FILT_LAST_W[7:0];
	localparam [3:0] HOLD_LOAD = HOLD_LOAD_W[3:0];

	// ==========================================
	// Input synchronisers

	reg [2:0] pin_s_q;
	reg [2:0] por_s_q;
	reg [2:0] bo_s_q;
	reg [2:0] reg_s_q;
	reg [2:0] rc_s_q;
	reg por_q;
	reg bo_q;
	reg reg_en_q;

	// Three stages; only stages two and three are looked at
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_s_q <= 3'h7;
			por_s_q <= 3'h0;
			bo_s_q <= 3'h0;
			reg_s_q <= 3'h0;
			rc_s_q <= 3'h0;
		end else begin
			pin_s_q <= {pin_s_q[1:0], external_reset_pin_n_i};
			por_s_q <= {por_s_q[1:0], power_on_i};
			bo_s_q <= {bo_s_q[1:0], brownout_i};
			reg_s_q <= {reg_s_q[1:0], regulator_enable_pin_i};
			rc_s_q <= {rc_s_q[1:0], internal_rc_clock_i};
		end
	end

	// New level of a chain: taken only once stages two and three agree,
	// so a bit caught mid-change in stage one never counts
	function settle;
		input [2:0] chain;
		input prev;
		if (chain[1] == chain[2])
			settle = chain[2];
		else
			settle = prev;
	endfunction

	// Levels of the supply inputs; all three share one rule
	always @(posedge clk_i) begin
		if (rst_i) begin
			por_q <= 1'b0;
			bo_q <= 1'b0;
			reg_en_q <= 1'b0;
		end else begin
			por_q <= settle(por_s_q, por_q);
			bo_q <= settle(bo_s_q, bo_q);
			reg_en_q <= settle(reg_s_q, reg_en_q);
		end
	end

	// Brown-out only counts with the regulator on
	wire bo_act = bo_q & reg_en_q;
	wire rc_edge = rc_s_q[1] & ~rc_s_q[2];

	// ==========================================
	// Pin glitch filter
	reg [7:0] filt_q;
	reg pin_low_q;

	// Low must stay for the whole filter span to count
	// Trade-off: a real pin reset is seen some cycles late
	always @(posedge clk_i) begin
		if (rst_i) begin
			filt_q <= 8'h00;
			pin_low_q <= 1'b0;
		end else if (pin_s_q[1] != pin_s_q[2]) begin
			filt_q <= 8'h00;
		end else if (pin_s_q[2] == pin_low_q) begin
			if (filt_q == FILT_LAST) begin
				pin_low_q <= ~pin_low_q;
				filt_q <= 8'h00;
			end else begin
				filt_q <= filt_q + 8'h01;
			end
		end else begin
			filt_q <= 8'h00;
		end
	end

	// ==========================================
	// Mismatch check and pulse sources
	reg [3:0] hold_q;
	reg core_q;
	wire cm_evt;
	wire pulse_evt;

	// Skipped in reset: the words are being reloaded then
	// Costs one compare per config bit, every cycle
	assign cm_evt = (cfg_word_i != ~cfg_shadow_i) & ~core_q;
	assign pulse_evt = cm_evt | reset_instr_i | watchdog_timeout_i;

	// Fixed hold for one-shot sources; a pin reset lasts only as long as the filtered pin stays low
	// A pulse inside the hold reloads it, so bursts merge into one reset
	always @(posedge clk_i) begin
		if (rst_i)
			hold_q <= 4'h0;
		else if (pulse_evt)
			hold_q <= HOLD_LOAD;
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
	end

	// ==========================================
	// Power-up timer
	reg [POWERUP_TIMER_BITS-1:0] pt_cnt_q;
	reg pt_run_q;

	// Held at zero during power-on or brown-out, then counts
	// Counts RC edges, so its span follows the RC clock, not clk_i
	always @(posedge clk_i) begin
		if (rst_i) begin
			pt_cnt_q <= {POWERUP_TIMER_BITS{1'b0}};
			pt_run_q <= 1'b1;
		end else if (por_q | bo_act) begin
			pt_cnt_q <= {POWERUP_TIMER_BITS{1'b0}};
			pt_run_q <= 1'b1;
		end else if (pt_run_q & rc_edge) begin
			if (pt_cnt_q == POWERUP_TIMER_LAST)
				pt_run_q <= 1'b0;
			else
				pt_cnt_q <= pt_cnt_q + 1'b1;
		end
	end

	// ==========================================
	// Core reset and reload strobe
	wire core_d = por_q | bo_act | pin_low_q | pt_run_q |
		(hold_q != 4'h0) | pulse_evt;

	// Pin is never driven: the timer runs independent of it
	// Any new reset source must be ORed into core_d as well
	always @(posedge clk_i) begin
		if (rst_i) begin
			core_q <= 1'b1;
			core_reset_o <= 1'b1;
			cfg_reload_o <= 1'b0;
			external_reset_pin_o <= 1'b0;
			external_reset_pin_oe_o <= 1'b0;
		end else begin
			core_q <= core_d;
			core_reset_o <= core_d;
			cfg_reload_o <= core_q & ~core_d;
			external_reset_pin_o <= 1'b0;
			external_reset_pin_oe_o <= 1'b0;
		end
	end

	// ==========================================
	// Status register
	reg [7:0] stat_q;
	reg [7:0] stat_d;
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire hit = (wb_adr_i == `RST_ADDR_STATUS);
	// Write lands at the edge the master samples ack, not a cycle early
	wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & hit &
		wb_sel_i[0];

	// Software first, hardware events after so they win
	// Bit 6 is forced last so that no path can set it
	always @* begin
		stat_d = stat_q;
		if (wr)
			stat_d = (stat_q & ~`RST_STATUS_WMASK) |
				(wb_dat_i[7:0] & `RST_STATUS_WMASK);
		if (watchdog_clear_instr_i) begin
			stat_d[`RST_BIT_TO] = 1'b1;
			stat_d[`RST_BIT_PD] = 1'b1;
		end
		if (sleep_instr_i) begin
			stat_d[`RST_BIT_TO] = 1'b1;
			stat_d[`RST_BIT_PD] = 1'b0;
		end
		if (watchdog_timeout_i)
			stat_d[`RST_BIT_TO] = 1'b0;
		if (reset_instr_i)
			stat_d[`RST_BIT_RI] = 1'b0;
		if (cm_evt)
			stat_d[`RST_BIT_CM] = 1'b0;
		if (bo_act)
			stat_d[`RST_BIT_BOR] = 1'b0;
		if (por_q) begin
			stat_d[`RST_BIT_CM] = 1'b1;
			stat_d[`RST_BIT_RI] = 1'b1;
			stat_d[`RST_BIT_TO] = 1'b1;
			stat_d[`RST_BIT_PD] = 1'b1;
			stat_d[`RST_BIT_POR] = 1'b0;
			stat_d[`RST_BIT_IRQ_PRIORITY_LEVELS_ON] = 1'b0;
			stat_d[`RST_BIT_BOR] = 1'b0;
		end
		if (~reg_en_q)
			stat_d[`RST_BIT_BOR] = 1'b0;
		stat_d[`RST_BIT_UNUSED] = 1'b0;
	end

	// Logic reset acts as a power-up
	always @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= `RST_STATUS_RESET;
			irq_priority_levels_on_o <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_priority_levels_on_o <= stat_d[`RST_BIT_IRQ_PRIORITY_LEVELS_ON];
		end
	end

	// ==========================================
	// Wishbone answer
	// One wait state; unmapped reads return zero
	// Ack drops the cycle after it is given, even if stb stays high
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req & ~wb_we_i & hit)
				wb_dat_o <= {24'h000000, stat_q};
			else
				wb_dat_o <= 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// ==== rst_chk_properties.sv ====
// Purpose: port checks for the reset tracker
// Assumes: bound to rst_source_tracker
// Notes: long holds cover the sync delays
`default_nettype none
module rst_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic external_reset_pin_n_i,
	input wire logic external_reset_pin_oe_o,
	input wire logic brownout_i,
	input wire logic regulator_enable_pin_i,
	input wire logic [15:0] cfg_word_i,
	input wire logic [15:0] cfg_shadow_i,
	input wire logic reset_instr_i,
	input wire logic core_reset_o,
	input wire logic cfg_reload_o,
	input wire logic irq_priority_levels_on_o
);
timeunit 1ns;
timeprecision 100ps;
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
// ==========================================
// Sequences
// Pin low past sync and filter
sequence s_pin_held;
	!external_reset_pin_n_i[*8] ##1 !external_reset_pin_n_i[*4];
endsequence
// ==========================================
// Properties
AST_PIN_OE: assert property (!external_reset_pin_oe_o)
	else $error("pin driven");
AST_PIN_RST: assert property (s_pin_held |-> core_reset_o)
	else $error("pin low, core free");
AST_SAG_RST: assert property
	((brownout_i && regulator_enable_pin_i)[*8] |-> core_reset_o)
	else $error("sag, core free");
AST_RI_HOLD: assert property (reset_instr_i |=> core_reset_o[*8])
	else $error("reset instr hold short");
AST_CM_RST: assert property
	(cfg_word_i != ~cfg_shadow_i && !core_reset_o |-> ##[1:2] core_reset_o)
	else $error("mismatch ignored");
AST_RELOAD: assert property (cfg_reload_o |-> $fell(core_reset_o))
	else $error("reload off release");
AST_BIT6: assert property (wb_ack_o |-> !wb_dat_o[6])
	else $error("bit 6 set");
AST_PRIO: assert property
	(wb_ack_o && !wb_we_i && wb_adr_i == 4'h0
	|-> wb_dat_o[7] == $past(irq_priority_levels_on_o))
	else $error("prio mirror");
endmodule
`default_nettype wire

// ==== rst_partner.sv ====
// Purpose: pin, supply and RC clock model
// Assumes: tb drives inputs at clock edges
// Notes: pin pulled up; RC runs at clk/8
`default_nettype none
module rst_partner (
	input wire logic clk_i,
	input wire logic press_i,
	input wire logic sag_i,
	input wire logic dev_o_i,
	input wire logic dev_oe_i,
	output logic pin_n_o,
	output logic bo_o,
	output logic rc_o
);
timeunit 1ns;
timeprecision 100ps;
logic [2:0] div_q = 3'h0;
// Device drive wins, else pull-up unless pressed
assign pin_n_o = dev_oe_i ? dev_o_i : !press_i;
// Supply monitor reports every sag; gating is the device's job
assign bo_o = sag_i;
assign rc_o = div_q[2];
// Free-running RC oscillator
always @(posedge clk_i) begin
	div_q <= div_q + 3'h1;
end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the reset tracker
// Assumes: classic Wishbone, byte lane 0 only
// Notes: timer cut to 4 RC edges for run time
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 100ps;
logic clk_i = 0, rst_i = 1, press = 0, sag = 0, reg_on = 1, por = 0;
logic cyc = 0, stb = 0, we = 0;
logic [3:0] adr = 0, ev = 0;
logic [31:0] dat = 0;
logic [15:0] shd = 16'hff00;
logic [7:0] q;
logic [7:0] exp_ev [4] = '{8'hbb, 8'hbf, 8'hb7, 8'ha7};
wire pin_n, bo, rc, pin_o, pin_oe, ack, crst, rld, prio;
wire [31:0] rdat;
int err_count = 0, n_tests = 0;
rst_source_tracker #(.POWERUP_TIMER_COUNT(4)) u_rst_source_tracker (
	.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
	.wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'h1), .wb_cyc_i(cyc),
	.wb_stb_i(stb), .wb_ack_o(ack), .external_reset_pin_n_i(pin_n),
	.external_reset_pin_o(pin_o), .external_reset_pin_oe_o(pin_oe),
	.power_on_i(por), .brownout_i(bo), .regulator_enable_pin_i(reg_on),
	.internal_rc_clock_i(rc), .cfg_word_i(16'h00ff), .cfg_shadow_i(shd),
	.reset_instr_i(ev[3]), .watchdog_clear_instr_i(ev[1]),
	.sleep_instr_i(ev[0]), .watchdog_timeout_i(ev[2]),
	.core_reset_o(crst), .cfg_reload_o(rld),
	.irq_priority_levels_on_o(prio));
rst_partner u_rst_partner (.clk_i(clk_i), .press_i(press), .sag_i(sag),
	.dev_o_i(pin_o), .dev_oe_i(pin_oe), .pin_n_o(pin_n),
	.bo_o(bo), .rc_o(rc));
// ==========================================
// Tasks
// One classic cycle; held until ack is seen
task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
	int n = 0;
	@(posedge clk_i);
	{cyc, stb, we} <= {2'b11, w};
	adr <= a;
	dat <= {24'h0, d};
	do @(posedge clk_i); while (ack !== 1'b1 && ++n < 40);
	chk("ack", 8'h01, {7'h0, ack});
	q = rdat[7:0];
	{cyc, stb, we} <= 3'h0;
endtask
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
	n_tests++;
	if (g !== e) begin
		err_count++;
		$display("BAD %s exp %h got %h", nm, e, g);
	end
endtask
task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
	bus(a, 0, 8'h00);
	chk(nm, e, q);
endtask
// Bounded wait for core release
task automatic rel;
	repeat (300) if (crst !== 1'b0) @(posedge clk_i);
	chk("release", 8'h00, {7'h0, crst});
	chk("reload", 8'h01, {7'h0, rld});
endtask
task automatic summarize;
	$display("errors %0d checks %0d", err_count, n_tests);
	if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
endtask
// ==========================================
// Clock, watchdog, tests
initial forever #2 clk_i = ~clk_i;
initial begin
	repeat (20000) @(posedge clk_i);
	err_count++;
	summarize();
end
initial begin
	repeat (12) @(posedge clk_i);
	rst_i <= 0;
	rel();
	rd("boot", 4'h0, 8'h3c);
	bus(4'h0, 1, 8'hff);
	rd("all", 4'h0, 8'hbf);
	chk("prio", 8'h01, {7'h0, prio});
	rd("unmapped", 4'h4, 8'h00);
	for (int i = 0; i < 4; i++) begin
		@(posedge clk_i) ev[i] <= 1;
		@(posedge clk_i) ev <= 0;
		rd("event", 4'h0, exp_ev[i]);
	end
	rel();
	@(posedge clk_i) shd <= 16'h00ff;
	@(posedge clk_i) shd <= 16'hff00;
	rd("mismatch", 4'h0, 8'h87);
	rel();
	@(posedge clk_i) sag <= 1;
	repeat (12) @(posedge clk_i);
	chk("sag", 8'h01, {7'h0, crst});
	sag <= 0;
	rel();
	rd("brownout", 4'h0, 8'h86);
	bus(4'h0, 1, 8'hff);
	reg_on <= 0;
	repeat (8) @(posedge clk_i);
	bus(4'h0, 1, 8'hff);
	rd("regoff", 4'h0, 8'hb6);
	sag <= 1;
	repeat (12) @(posedge clk_i);
	chk("sagoff", 8'h00, {7'h0, crst});
	sag <= 0;
	repeat (8) @(posedge clk_i);
	reg_on <= 1;
	press <= 1;
	repeat (3) @(posedge clk_i);
	press <= 0;
	repeat (12) @(posedge clk_i);
	chk("glitch", 8'h00, {7'h0, crst});
	press <= 1;
	repeat (60) @(posedge clk_i);
	chk("pin", 8'h01, {7'h0, crst});
	press <= 0;
	repeat (20) @(posedge clk_i);
	chk("late", 8'h00, {7'h0, crst});
	rd("kept", 4'h0, 8'hb6);
	bus(4'h0, 1, 8'h80);
	@(posedge clk_i) por <= 1;
	repeat (10) @(posedge clk_i);
	por <= 0;
	rel();
	rd("poweron", 4'h0, 8'h3c);
	chk("prio0", 8'h00, {7'h0, prio});
	summarize();
end
endmodule
bind rst_source_tracker rst_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o),
	.external_reset_pin_n_i(external_reset_pin_n_i),
	.external_reset_pin_oe_o(external_reset_pin_oe_o),
	.brownout_i(brownout_i),
	.regulator_enable_pin_i(regulator_enable_pin_i),
	.cfg_word_i(cfg_word_i), .cfg_shadow_i(cfg_shadow_i),
	.reset_instr_i(reset_instr_i), .core_reset_o(core_reset_o),
	.cfg_reload_o(cfg_reload_o),
	.irq_priority_levels_on_o(irq_priority_levels_on_o));
`default_nettype wire
